/* File: dv/tec_pulse_src.sv */
// external event source that drives the counter input pin
`timescale 1ns/1ps
`default_nettype none

module tec_pulse_src (
  // clock of the bench
  input  wire logic pclk,
  // pin toward the counter
  output var  logic pin
);
  // the pin idles low until the bench asks for transitions
  initial pin = 1'b0;

  // set a level just after an edge and hold it for n cycles
  task automatic hold(input logic lvl, input int n);
    @(posedge pclk);
    pin <= lvl;
    repeat (n) @(posedge pclk);
  endtask

  // toggle the pin n times, one change every k+1 cycles (the hold of k plus the next call's wait for an edge)
  task automatic toggle(input int n, input int k);
    for (int i = 0; i < n; i++) begin
      hold(~pin, k);
    end
  endtask
endmodule

`default_nettype wire

/* File: dv/tec_timer_tb.sv */
// self-checking bench of the timer/event counter
`timescale 1ns/1ps
`default_nettype none

module tec_timer_tb;
  import tec_pkg::*;
  // design inputs and outputs
  logic        pclk, presetn, psel, penable, pwrite, power_down;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, timer_irq, pin;
  // last read answer and tallies
  logic [31:0] rv;
  logic        err;
  int          n_fail, checks_done;

  tec_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .counter_input_pin(pin), .power_down(power_down),
    .timer_irq(timer_irq));
  tec_pulse_src i_src (.pclk(pclk), .pin(pin));

  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // compare one value
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // compare a value against an inclusive range
  task automatic chk_in(string nm, int lo, int hi, logic [31:0] g);
    checks_done++;
    if ($isunknown(g) || g < lo || g > hi) begin
      n_fail++;
      $display("[FAIL] %s expected %0d..%0d seen %h", nm, lo, hi, g);
    end
  endtask

  // one apb transfer: setup, access held until pready, then release
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int t = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // hold the request until the rising edge that samples pready high
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      complete_run();
    end
    // answer taken at that same edge, then the request is released
    rv  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h00000000);
  endtask

  // 16-bit count read: high first latches the low byte
  task automatic rd16(output logic [15:0] c);
    rd(ADDR_COUNT_HIGH);
    c[15:8] = rv[7:0];
    rd(ADDR_COUNT_LOW);
    c[7:0] = rv[7:0];
  endtask

  // preload: low byte first, the high write commits both
  task automatic load(input logic [15:0] v);
    wr(ADDR_COUNT_LOW, v[7:0]);
    wr(ADDR_COUNT_HIGH, v[15:8]);
  endtask

  // reset values, spare bits and an unmapped address
  task automatic t_reset();
    logic [7:0] a[4] = '{ADDR_COUNT_LOW, ADDR_COUNT_HIGH, ADDR_CONTROL,
                         ADDR_IRQ_CTRL};
    foreach (a[i]) begin
      rd(a[i]);
      chk("reset value", 32'h00000000, rv);
      chk("ok response", 32'h00000000, {31'h0, err});
    end
    apb(1'b0, 8'h10, 32'h00000000);
    chk("unmapped err", 32'h00000001, {31'h0, err});
    chk("unmapped data", 32'h00000000, rv);
    wr(ADDR_CONTROL, 8'h27);
    rd(ADDR_CONTROL);
    chk("spare bits", 32'h00000000, rv);
  endtask

  // byte buffering of preload and count reads
  task automatic t_preload();
    logic [15:0] c;
    load(16'hAA9B);
    rd16(c);
    chk("stopped preload", 32'h0000AA9B, {16'h0, c});
    wr(ADDR_COUNT_LOW, 8'h11);
    rd(ADDR_COUNT_HIGH);
    chk("high byte", 32'h000000AA, rv);
    rd(ADDR_COUNT_LOW);
    chk("latched low", 32'h0000009B, rv);
  endtask

  // interval timer: reload, request flag, enable gating
  task automatic t_timer();
    wr(ADDR_IRQ_CTRL, 8'h00);
    load(16'hFFF0);
    wr(ADDR_CONTROL, 8'h80);
    wr(ADDR_CONTROL, 8'h90);
    load(16'h8000);
    rd(ADDR_COUNT_HIGH);
    chk("running preload", 32'h000000FF, rv);
    rd(ADDR_IRQ_CTRL);
    for (int i = 0; i < 40 && rv[IRQ_REQUEST_BIT] !== 1'b1; i++) begin
      rd(ADDR_IRQ_CTRL);
    end
    chk("request flag", 32'h00000001, {31'h0, rv[IRQ_REQUEST_BIT]});
    if (rv[IRQ_REQUEST_BIT] !== 1'b1) complete_run();
    @(negedge pclk);
    chk("irq masked", 32'h00000000, {31'h0, timer_irq});
    rd(ADDR_COUNT_HIGH);
    chk("reloaded", 32'h00000080, rv);
    wr(ADDR_CONTROL, 8'h80);
    load(16'hFFFE);
    wr(ADDR_IRQ_CTRL, 8'h03);
    wr(ADDR_CONTROL, 8'h90);
    for (int t = 0; t < 100 && timer_irq !== 1'b1; t++) @(negedge pclk);
    chk("irq raised", 32'h00000001, {31'h0, timer_irq});
    if (timer_irq !== 1'b1) complete_run();
    rd(ADDR_CONTROL);
    chk("run kept", 32'h00000090, rv);
    wr(ADDR_CONTROL, 8'h80);
    wr(ADDR_IRQ_CTRL, 8'h02);
    rd(ADDR_COUNT_HIGH);
    chk("stopped", 32'h000000FF, rv);
  endtask

  // event counting on both edge choices, while powered down
  task automatic t_event();
    logic [15:0] c;
    power_down <= 1'b1;
    for (int e = 0; e < 2; e++) begin
      wr(ADDR_CONTROL, 8'h40);
      load(16'h0000);
      wr(ADDR_CONTROL, 8'h50 | 8'(e << CTRL_EDGE_BIT));
      i_src.toggle(3, 6);
      repeat (6) @(posedge pclk);
      rd16(c);
      chk("event count", 32'h00000002, {16'h0, c});
    end
    power_down <= 1'b0;
  endtask

  // single-shot pulse width on both polarities
  task automatic t_pulse();
    logic [15:0] c;
    logic [15:0] d;
    logic        e;
    for (int k = 0; k < 2; k++) begin
      e = k[0];
      i_src.hold(~e, 8);
      wr(ADDR_CONTROL, 8'hC0 | {4'h0, e, 3'h0});
      load(16'h0000);
      wr(ADDR_CONTROL, 8'hD0 | {4'h0, e, 3'h0});
      i_src.hold(e, 40);
      i_src.hold(~e, 8);
      rd(ADDR_CONTROL);
      chk("run cleared", {24'h0, 8'hC0 | {4'h0, e, 3'h0}}, rv);
      rd16(c);
      chk_in("pulse width", 36, 44, {16'h0, c});
      i_src.toggle(4, 6);
      repeat (6) @(posedge pclk);
      rd16(d);
      chk("held count", {16'h0, c}, {16'h0, d});
    end
  endtask

  // reset, scenarios, verdict
  initial begin
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h00000000;
    power_down  = 1'b0;
    n_fail      = 0;
    checks_done = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_preload();
    t_timer();
    t_event();
    t_pulse();
    complete_run();
  end

  // overall limit on the run
  initial begin
    repeat (100000) @(posedge pclk);
    n_fail++;
    complete_run();
  end
endmodule

`default_nettype wire

/* File: hw/tec_pkg.sv */
// shared constants and types of the 16-bit timer/event counter
package tec_pkg;

  // apb register byte addresses
  localparam logic [7:0] ADDR_COUNT_LOW  = 8'h00;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h04;
  localparam logic [7:0] ADDR_CONTROL    = 8'h08;
  localparam logic [7:0] ADDR_IRQ_CTRL   = 8'h0C;

  // counter_control field positions
  localparam int CTRL_MODE_HIGH_BIT = 7;
  localparam int CTRL_MODE_LOW_BIT  = 6;
  localparam int CTRL_RUN_BIT       = 4;
  localparam int CTRL_EDGE_BIT      = 3;

  // irq_control field positions
  localparam int IRQ_ENABLE_BIT  = 0;
  localparam int IRQ_REQUEST_BIT = 1;

  // reset values
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;

  // overflow point of the count
  localparam logic [15:0] COUNT_FULL = 16'hFFFF;

  // mode field encodings {mode_select_high, mode_select_low}
  localparam logic [1:0] MODE_OFF   = 2'b00;
  localparam logic [1:0] MODE_TIMER = 2'b10;
  localparam logic [1:0] MODE_EVENT = 2'b01;
  localparam logic [1:0] MODE_PULSE = 2'b11;

  // counter_control layout
  typedef struct packed {
    logic       mode_select_high;  // bit 7
    logic       mode_select_low;   // bit 6
    logic       spare5;            // bit 5, reads zero
    logic       run_bit;           // bit 4
    logic       edge_select;       // bit 3
    logic [2:0] spare;             // bits 2..0, read zero
  } tec_ctrl_s;

  // pulse width measurement states
  typedef enum logic {
    PW_WAIT,     // armed, waiting for the starting transition
    PW_MEASURE   // pulse in progress, counting
  } tec_pw_e;

endpackage

/* File: hw/tec_timer.sv */
// 16-bit timer/event counter with apb register access
//
// Contract
// R01: system clock in timer/pulse, pin in event
// R02: count up, overflow reloads preload, raises interrupt
// R03: stopped preload write loads counter immediately
// R04: low write buffers, high write commits both
// R05: high read latches low; low reads buffer
// R06: bit 4 run bit starts/stops counter
// R07: bit 3 edge select picks active polarity
// R08: mode high=1 low=0 is interval timer
// R09: overflow never wakes from power-down
// R10: mode high=0 low=1 is event counting
// R11: event edge rising if select low else falling
// R12: event counting continues during power-down
// R13: both mode bits high: pulse width mode
// R14: select low: start falling, stop rising
// R15: select high: start rising, stop falling
// R16: hardware clears run only in pulse mode
// R17: after pulse end, hold until run set
// R18: pulse gating uses transitions, not levels
// R19: interrupt suppressed when enable bit zero
// R20: software selects mode, makes pin input
// R21: software writes low byte before high
// R22: overflow sets request flag regardless enable
// R23: counting inhibited during register access
// R24: pin synchronised, edges from synced signal
`timescale 1ns/1ps
`default_nettype none

module tec_timer
  import tec_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // external pulse source and power state
  input  wire logic        counter_input_pin,
  input  wire logic        power_down,
  // timer interrupt signal to the interrupt controller
  output var  logic        timer_irq
);

  // register state
  tec_ctrl_s   ctrl;            // counter_control
  logic [15:0] count;           // live counter
  logic [15:0] preload;         // reload value
  logic [7:0]  low_buffer;      // shared low byte buffer
  logic        counter_irq_enable;
  logic        irq_request;     // sticky overflow flag
  tec_pw_e     pw_state;        // pulse measurement phase

  // pin synchroniser and edge history
  logic        pin_meta;        // first stage, read only by pin_sync
  logic        pin_sync;        // second stage
  logic        pin_prev;        // delayed copy for edge detection

  // decoded strobes
  logic        access;          // access edge of an apb transfer
  logic        wr_low;
  logic        wr_high;
  logic        wr_ctrl;
  logic        wr_irq;
  logic        rd_high;
  logic        addr_ok;         // address is mapped
  logic        rise;            // synced rising transition
  logic        fall;            // synced falling transition
  logic        active_edge;     // event edge chosen by edge_select
  logic        pw_start;        // transition that opens a pulse
  logic        pw_stop;         // transition that closes a pulse
  logic [1:0]  mode;
  logic        inhibit;         // freeze counting during access
  logic        step;            // counter advances this cycle
  logic        overflow;        // step at full count
  logic        pw_end;          // pulse finished this cycle
  logic [15:0] next_preload;
  logic [31:0] next_rdata;

  // transfer completes at the edge where pready is seen high
  assign access  = psel && penable && pready;
  assign addr_ok = (paddr == ADDR_COUNT_LOW)  || (paddr == ADDR_COUNT_HIGH)
                || (paddr == ADDR_CONTROL)    || (paddr == ADDR_IRQ_CTRL);
  assign wr_low  = access && pwrite && (paddr == ADDR_COUNT_LOW);
  assign wr_high = access && pwrite && (paddr == ADDR_COUNT_HIGH);
  assign wr_ctrl = access && pwrite && (paddr == ADDR_CONTROL);
  assign wr_irq  = access && pwrite && (paddr == ADDR_IRQ_CTRL);
  assign rd_high = access && !pwrite && (paddr == ADDR_COUNT_HIGH);

  // mode and edges
  assign mode        = {ctrl.mode_select_high, ctrl.mode_select_low};
  assign rise        = pin_sync && !pin_prev;                    // R24
  assign fall        = !pin_sync && pin_prev;                    // R24
  assign active_edge = ctrl.edge_select ? fall : rise;           // R07 R11
  // a pulse opens on the edge opposite the event edge: select low
  // waits for a falling pin, select high for a rising one
  assign pw_start    = ctrl.edge_select ? rise : fall;           // R07 R14 R15
  assign pw_stop     = ctrl.edge_select ? fall : rise;           // R07 R14 R15
  // whole transfer holds the count steady, so a read sees one value
  assign inhibit     = psel;                                     // R23

  // count enable per mode
  always_comb begin
    step = 1'b0;
    if (ctrl.run_bit && !inhibit) begin                          // R06
      unique case (mode)
        // internal clock, stopped while the system clock is halted
        MODE_TIMER: step = !power_down;                          // R01 R08
        // pin transitions, keep running in power-down
        MODE_EVENT: step = active_edge;                          // R10 R11 R12
        // internal clock gated by the measured pulse
        MODE_PULSE: step = !power_down && (pw_state == PW_MEASURE)
                           && !pw_stop;                          // R13 R18
        // mode 00: nothing drives the count
        MODE_OFF:   step = 1'b0;
      endcase
    end
  end

  assign overflow = step && (count == COUNT_FULL);               // R02
  assign pw_end   = ctrl.run_bit && (mode == MODE_PULSE)
                    && (pw_state == PW_MEASURE) && pw_stop;      // R14 R15

  // preload value after a high byte write joins the buffered low byte
  assign next_preload = {pwdata[7:0], low_buffer};               // R04

  // pin synchroniser, two stages then history for edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_meta <= counter_input_pin;                             // R24
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // control register; hardware clears run only at pulse end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= tec_ctrl_s'(CONTROL_RESET);
    end else if (wr_ctrl) begin
      // spare bits are not stored and read zero
      ctrl                  <= tec_ctrl_s'(CONTROL_RESET);
      ctrl.mode_select_high <= pwdata[CTRL_MODE_HIGH_BIT];
      ctrl.mode_select_low  <= pwdata[CTRL_MODE_LOW_BIT];
      ctrl.run_bit          <= pwdata[CTRL_RUN_BIT];             // R06
      ctrl.edge_select      <= pwdata[CTRL_EDGE_BIT];            // R07
    end else if (pw_end) begin
      ctrl.run_bit <= 1'b0;                                      // R14 R15 R16
    end
  end

  // pulse measurement phase: armed, then measuring until return edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pw_state <= PW_WAIT;
    end else if (!ctrl.run_bit || mode != MODE_PULSE) begin
      // stopped: later transitions are ignored
      pw_state <= PW_WAIT;                                       // R17
    end else begin
      unique case (pw_state)
        PW_WAIT: begin
          if (pw_start) begin
            pw_state <= PW_MEASURE;                              // R14 R15 R18
          end
        end
        PW_MEASURE: begin
          if (pw_stop) begin
            pw_state <= PW_WAIT;                                 // R14 R15
          end
        end
      endcase
    end
  end

  // preload register, written through the high byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      preload <= COUNT_RESET;
    end else if (wr_high) begin
      preload <= next_preload;                                   // R04
    end
  end

  // low byte buffer: filled by a low write or by a high read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_buffer <= BYTE_RESET;
    end else if (wr_low) begin
      low_buffer <= pwdata[7:0];                                 // R04
    end else if (rd_high) begin
      low_buffer <= count[7:0];                                  // R05
    end
  end

  // live counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= COUNT_RESET;
    end else if (wr_high && !ctrl.run_bit) begin
      // stopped: new preload goes straight into the count
      count <= next_preload;                                     // R03
    end else if (overflow) begin
      // running preload writes reach the count only here
      count <= preload;                                          // R02 R03
    end else if (step) begin
      count <= count + 16'h0001;                                 // R02
    end
  end

  // interrupt control: enable bit and sticky request flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_irq_enable <= 1'b0;
      irq_request        <= 1'b0;
    end else begin
      if (wr_irq) begin
        counter_irq_enable <= pwdata[IRQ_ENABLE_BIT];
      end
      if (overflow) begin
        // overflow wins over a clearing write in the same cycle
        irq_request <= 1'b1;                                     // R22
      end else if (wr_irq && pwdata[IRQ_REQUEST_BIT]) begin
        irq_request <= 1'b0;
      end
    end
  end

  // interrupt output; no wake-up path exists for an overflow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= irq_request && counter_irq_enable;            // R19 R09
    end
  end

  // read mux, evaluated in the setup cycle
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (paddr)
      ADDR_COUNT_LOW:  next_rdata[7:0] = low_buffer;             // R05
      ADDR_COUNT_HIGH: next_rdata[7:0] = count[15:8];            // R05
      ADDR_CONTROL:    next_rdata[7:0] = ctrl;
      ADDR_IRQ_CTRL: begin
        next_rdata[IRQ_ENABLE_BIT]  = counter_irq_enable;
        next_rdata[IRQ_REQUEST_BIT] = irq_request;
      end
      default:         next_rdata = 32'h0000_0000;
    endcase
  end

  // apb answer: one access cycle, registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && !penable) begin
      // setup cycle: prepare the answer for the access cycle
      pready  <= 1'b1;
      pslverr <= !addr_ok;
      prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

  // checks
  a_full_reload: assert property (@(posedge pclk) disable iff (!presetn)
    overflow && !(wr_high && !ctrl.run_bit) |=> count == $past(preload)) // R02
    else $error("count did not reload preload after overflow");

  a_stopped_load: assert property (@(posedge pclk) disable iff (!presetn)
    wr_high && !ctrl.run_bit |=> count == preload)               // R03
    else $error("stopped preload write did not load the count");

  a_running_hold: assert property (@(posedge pclk) disable iff (!presetn)
    wr_high && ctrl.run_bit && !overflow |=> count == $past(count)) // R03
    else $error("running preload write disturbed the count");

  a_low_buffer: assert property (@(posedge pclk) disable iff (!presetn)
    wr_low |=> low_buffer == $past(pwdata[7:0]) && preload == $past(preload)) // R04
    else $error("low byte write not held in buffer only");

  a_high_latch: assert property (@(posedge pclk) disable iff (!presetn)
    rd_high |=> low_buffer == $past(count[7:0]))                 // R05
    else $error("high read did not latch low byte");

  a_stop_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl.run_bit && !wr_high |=> $stable(count))                // R06
    else $error("count moved while stopped");

  a_event_edge: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.run_bit && mode == MODE_EVENT && !psel && !overflow
    && (ctrl.edge_select ? fall : rise) && !wr_high
    |=> count == $past(count) + 16'h0001)                        // R11
    else $error("event edge did not advance the count");

  a_pulse_clear: assert property (@(posedge pclk) disable iff (!presetn)
    pw_end && !wr_ctrl |=> !ctrl.run_bit
    ##1 ($stable(count) || $past(wr_high)))                      // R14
    else $error("pulse end did not stop the counter");

  a_run_software: assert property (@(posedge pclk) disable iff (!presetn)
    mode != MODE_PULSE && !wr_ctrl |=> ctrl.run_bit == $past(ctrl.run_bit)) // R16
    else $error("run bit changed without a write");

  a_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    overflow |=> irq_request ##1 (timer_irq == counter_irq_enable
    || $past(wr_irq)))                                           // R22
    else $error("overflow did not set the request flag");

  a_irq_mask: assert property (@(posedge pclk) disable iff (!presetn)
    !counter_irq_enable |=> !timer_irq)                          // R19
    else $error("interrupt raised while disabled");

  a_access_freeze: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !wr_high |=> $stable(count))                         // R23
    else $error("count moved during a register access");

endmodule

`default_nettype wire
